//--- src/mtsl_pkg.sv
// Constants, register map and carrier types of the measurement timer block.
// Assumes a 32-bit Avalon-MM slave on a 20 MHz clock with synchronous reset.
// How it works
// - The 5-bit source selector routes one of seventeen inputs (0 = pin, 16 = seconds tick) to the measured signal and resets to 0.
// - Selector bits 7 to 5 ignore writes and read as zero.
// - The main counter is 24 bits, read and written as three bytes, and clears on every reset.
// - The period latch is three read-only bytes, ignores writes, and is undefined until its first capture.
// - The width latch is three read-only bytes, ignores writes, and is undefined until its first capture.
// - The match limit is three writable bytes and is set to all ones by reset.
// - When the counter equals the match limit it rolls over to zero and raises the period match event.
// - With halt_at_limit set the counter holds at the limit instead, and the match event still fires when clocked.
// - A width update request copies the counter into the width latch and is cleared by hardware when done.
// - A period update request copies the counter into the period latch and is cleared by hardware when done.
package mtsl_pkg;
   localparam int          ADDR_W          = 5;
   localparam int          CNT_W           = 24;
   localparam int          SEL_W           = 5;
   localparam int          NUM_SRC         = 17;
   // Word addresses (byte address divided by four).
   localparam logic [4:0]  A_SIG           = 5'h00;
   localparam logic [4:0]  A_TMR_L         = 5'h01;
   localparam logic [4:0]  A_TMR_H         = 5'h02;
   localparam logic [4:0]  A_TMR_U         = 5'h03;
   localparam logic [4:0]  A_CPR_L         = 5'h04;
   localparam logic [4:0]  A_CPR_H         = 5'h05;
   localparam logic [4:0]  A_CPR_U         = 5'h06;
   localparam logic [4:0]  A_CPW_L         = 5'h07;
   localparam logic [4:0]  A_CPW_H         = 5'h08;
   localparam logic [4:0]  A_CPW_U         = 5'h09;
   localparam logic [4:0]  A_LIM_L         = 5'h0a;
   localparam logic [4:0]  A_LIM_H         = 5'h0b;
   localparam logic [4:0]  A_LIM_U         = 5'h0c;
   localparam logic [4:0]  A_CTRL          = 5'h0d;
   localparam logic [4:0]  A_STAT          = 5'h0e;
   localparam logic [4:0]  A_IRQ_ST        = 5'h0f;
   localparam logic [4:0]  A_IRQ_MSK       = 5'h10;
   // Control register fields.
   localparam int          CTRL_GO         = 0;
   localparam int          CTRL_HALT       = 1;
   // Status register fields.
   localparam int          ST_PRUP         = 0;
   localparam int          ST_WUP          = 1;
   localparam int          ST_RST          = 2;
   localparam int          ST_SIG          = 3;
   // Interrupt status fields.
   localparam int          IRQ_MATCH       = 0;
   localparam int          IRQ_PCAP        = 1;
   localparam int          IRQ_WCAP        = 2;
   localparam int          IRQ_W           = 3;
   localparam logic [4:0]  SEL_RST         = 5'h00;
   localparam logic [23:0] CNT_RST         = 24'h000000;
   localparam logic [23:0] LIM_RST         = 24'hffffff;
   localparam logic [31:0] UNMAPPED_DATA   = 32'h00000000;

   typedef struct packed {
      logic                pin;
      logic                t0_wrap;
      logic                t1_wrap;
      logic                t2_post;
      logic                t4_post;
      logic                ccp1;
      logic                ccp2;
      logic                pwm3;
      logic                pwm4;
      logic                cmp1;
      logic                cmp2;
      logic                zcd;
      logic                clc1;
      logic                clc2;
      logic                clc3;
      logic                clc4;
      logic                sec_tick;
   } mtsl_src_type;

   typedef struct packed {
      logic                read;
      logic                write;
      logic [4:0]          address;
      logic [31:0]         writedata;
   } mtsl_req_type;
endpackage : mtsl_pkg

//--- src/mtsl_src_mux.sv
// Signal source multiplexer of the measurement timer.
// Assumes all source inputs are synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module mtsl_src_mux (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic [4:0]            sel,
   input  wire mtsl_pkg::mtsl_src_type src,
   output logic                       sig_out
);
   logic [16:0] flat;

   // Bit 0 of the flat vector is the pin, bit 16 the seconds tick.
   always_comb begin
      for (int i = 0; i < mtsl_pkg::NUM_SRC; i++) begin
         flat[i] = src[mtsl_pkg::NUM_SRC - 1 - i];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sig_out <= 1'b0;
      end else if (sel > 5'h10) begin
         sig_out <= 1'b0;
      end else begin
         sig_out <= flat[sel];
      end
   end
endmodule : mtsl_src_mux
`default_nettype wire

//--- src/mtsl_top.sv
// Signal selection, counter, latches and match limit of the measurement
// timer, behind an Avalon-MM slave with a single level interrupt.
// Assumes the counter clock enable comes from an upstream prescaler.
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module mtsl_top (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic [4:0]             avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   output logic [31:0]                 avs_readdata,
   output logic                        avs_waitrequest,
   input  wire logic                   count_tick,
   input  wire mtsl_pkg::mtsl_src_type src_in,
   input  wire logic                   period_capture,
   input  wire logic                   width_capture,
   output logic                        measured_signal,
   output logic                        period_match,
   output logic                        irq
);
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      MTSL_BUS_IDLE   = 2'b01,
      MTSL_BUS_ANSWER = 2'b10
   } mtsl_bus_state_type;

   mtsl_bus_state_type bus_state_reg;
   mtsl_bus_state_type bus_state_next;
   logic [4:0]  sel_reg;
   logic [23:0] cnt_reg;
   logic [23:0] cnt_next;
   logic [23:0] cpr_reg;
   logic [23:0] cpw_reg;
   logic [23:0] lim_reg;
   logic        go_reg;
   logic        halt_reg;
   logic        prup_reg;
   logic        wup_reg;
   logic        trst_reg;
   logic [2:0]  irq_st_reg;
   logic [2:0]  irq_msk_reg;
   logic [2:0]  irq_set;
   logic [2:0]  irq_clr;
   logic        ack;
   logic        wr;
   logic        match;
   logic        match_event;
   logic        p_cap;
   logic        w_cap;
   logic        sig_mux;
   logic [31:0] rd_mux;

   assign ack         = (bus_state_reg == MTSL_BUS_ANSWER);
   assign wr          = avs_write && ack;
   assign match       = (cnt_reg == lim_reg);
   assign match_event = go_reg && count_tick && match;
   assign p_cap = prup_reg || period_capture;
   assign w_cap = wup_reg || width_capture;

   mtsl_src_mux u_mux (
      .clk     (clk),
      .rst     (rst),
      .sel     (sel_reg),
      .src     (src_in),
      .sig_out (sig_mux)
   );

   ////////////////////////////////////////////////////////////////////////
   // One wait state: a request is answered in the cycle after it is seen.
   // The answer cycle never takes a new request, so a request that the
   // master still holds at the answer edge is not taken a second time.
   always_comb begin
      bus_state_next = bus_state_reg;
      case (bus_state_reg)
         MTSL_BUS_IDLE: begin
            if (avs_read || avs_write) begin
               bus_state_next = MTSL_BUS_ANSWER;
            end
         end
         MTSL_BUS_ANSWER: begin
            bus_state_next = MTSL_BUS_IDLE;
         end
         default: begin
            bus_state_next = MTSL_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bus_state_reg <= MTSL_BUS_IDLE;
      end else begin
         bus_state_reg <= bus_state_next;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= (bus_state_next != MTSL_BUS_ANSWER);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sel_reg <= mtsl_pkg::SEL_RST;
      end else if (wr && avs_address == mtsl_pkg::A_SIG) begin
         sel_reg <= avs_writedata[4:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lim_reg <= mtsl_pkg::LIM_RST;
      end else if (wr) begin
         case (avs_address)
            mtsl_pkg::A_LIM_L: lim_reg[7:0]   <= avs_writedata[7:0];
            mtsl_pkg::A_LIM_H: lim_reg[15:8]  <= avs_writedata[7:0];
            mtsl_pkg::A_LIM_U: lim_reg[23:16] <= avs_writedata[7:0];
            default: lim_reg <= lim_reg;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         go_reg <= 1'b0;
      end else if (wr && avs_address == mtsl_pkg::A_CTRL) begin
         go_reg <= avs_writedata[mtsl_pkg::CTRL_GO];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         halt_reg <= 1'b0;
      end else if (wr && avs_address == mtsl_pkg::A_CTRL) begin
         halt_reg <= avs_writedata[mtsl_pkg::CTRL_HALT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Request bits are taken from software and cleared once the copy or the counter clear has
   // been made, which always happens in the cycle after they are set.
   always_ff @(posedge clk) begin
      if (rst) begin
         prup_reg <= 1'b0;
      end else if (wr && avs_address == mtsl_pkg::A_STAT) begin
         prup_reg <= avs_writedata[mtsl_pkg::ST_PRUP];
      end else begin
         prup_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wup_reg <= 1'b0;
      end else if (wr && avs_address == mtsl_pkg::A_STAT) begin
         wup_reg <= avs_writedata[mtsl_pkg::ST_WUP];
      end else begin
         wup_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         trst_reg <= 1'b0;
      end else if (wr && avs_address == mtsl_pkg::A_STAT) begin
         trst_reg <= avs_writedata[mtsl_pkg::ST_RST];
      end else begin
         trst_reg <= 1'b0;
      end
   end

   // Latches have no reset: their value is undefined until a capture.
   always_ff @(posedge clk) begin
      if (p_cap) begin
         cpr_reg <= cnt_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (w_cap) begin
         cpw_reg <= cnt_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      cnt_next = cnt_reg;
      if (trst_reg) begin
         cnt_next = mtsl_pkg::CNT_RST;
      end else if (go_reg && count_tick) begin
         if (match) begin
            cnt_next = halt_reg ? lim_reg : mtsl_pkg::CNT_RST;
         end else begin
            cnt_next = cnt_reg + 24'h000001;
         end
      end
      // Software writes win; the counter is not guarded for atomic access.
      if (wr) begin
         case (avs_address)
            mtsl_pkg::A_TMR_L: cnt_next[7:0]   = avs_writedata[7:0];
            mtsl_pkg::A_TMR_H: cnt_next[15:8]  = avs_writedata[7:0];
            mtsl_pkg::A_TMR_U: cnt_next[23:16] = avs_writedata[7:0];
            default: cnt_next = cnt_next;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= mtsl_pkg::CNT_RST;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         period_match <= 1'b0;
      end else begin
         period_match <= match_event;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         measured_signal <= 1'b0;
      end else begin
         measured_signal <= sig_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      irq_set = 3'h0;
      irq_set[mtsl_pkg::IRQ_MATCH] = match_event;
      irq_set[mtsl_pkg::IRQ_PCAP]  = p_cap;
      irq_set[mtsl_pkg::IRQ_WCAP]  = w_cap;
      irq_clr = 3'h0;
      if (wr && avs_address == mtsl_pkg::A_IRQ_ST) begin
         irq_clr = avs_writedata[2:0];
      end
   end

   // A new event wins over a write-one-to-clear in the same cycle.
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_st_reg <= 3'h0;
      end else begin
         irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_set;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_msk_reg <= 3'h0;
      end else if (wr && avs_address == mtsl_pkg::A_IRQ_MSK) begin
         irq_msk_reg <= avs_writedata[2:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_st_reg & irq_msk_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      rd_mux = mtsl_pkg::UNMAPPED_DATA;
      case (avs_address)
         mtsl_pkg::A_SIG:     rd_mux[4:0] = sel_reg;
         mtsl_pkg::A_TMR_L:   rd_mux[7:0] = cnt_reg[7:0];
         mtsl_pkg::A_TMR_H:   rd_mux[7:0] = cnt_reg[15:8];
         mtsl_pkg::A_TMR_U:   rd_mux[7:0] = cnt_reg[23:16];
         mtsl_pkg::A_CPR_L:   rd_mux[7:0] = cpr_reg[7:0];
         mtsl_pkg::A_CPR_H:   rd_mux[7:0] = cpr_reg[15:8];
         mtsl_pkg::A_CPR_U:   rd_mux[7:0] = cpr_reg[23:16];
         mtsl_pkg::A_CPW_L:   rd_mux[7:0] = cpw_reg[7:0];
         mtsl_pkg::A_CPW_H:   rd_mux[7:0] = cpw_reg[15:8];
         mtsl_pkg::A_CPW_U:   rd_mux[7:0] = cpw_reg[23:16];
         mtsl_pkg::A_LIM_L:   rd_mux[7:0] = lim_reg[7:0];
         mtsl_pkg::A_LIM_H:   rd_mux[7:0] = lim_reg[15:8];
         mtsl_pkg::A_LIM_U:   rd_mux[7:0] = lim_reg[23:16];
         mtsl_pkg::A_CTRL: begin
            rd_mux[mtsl_pkg::CTRL_GO]   = go_reg;
            rd_mux[mtsl_pkg::CTRL_HALT] = halt_reg;
         end
         mtsl_pkg::A_STAT: begin
            rd_mux[mtsl_pkg::ST_PRUP] = prup_reg;
            rd_mux[mtsl_pkg::ST_WUP]  = wup_reg;
            rd_mux[mtsl_pkg::ST_RST]  = trst_reg;
            rd_mux[mtsl_pkg::ST_SIG]  = measured_signal;
         end
         mtsl_pkg::A_IRQ_ST:  rd_mux[2:0] = irq_st_reg;
         mtsl_pkg::A_IRQ_MSK: rd_mux[2:0] = irq_msk_reg;
         default:             rd_mux = mtsl_pkg::UNMAPPED_DATA;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         avs_readdata <= mtsl_pkg::UNMAPPED_DATA;
      end else if (avs_read && !ack) begin
         avs_readdata <= rd_mux;
      end
   end
endmodule : mtsl_top
`default_nettype wire

//--- test/mtsl_checker.sv
// Port checker of the measurement timer: bus timing, routing, interrupt.
// Assumes it is bound to mtsl_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module mtsl_checker (
   input wire logic                   clk,
   input wire logic                   rst,
   input wire logic [4:0]             avs_address,
   input wire logic                   avs_read,
   input wire logic                   avs_write,
   input wire logic [31:0]            avs_writedata,
   input wire logic [31:0]            avs_readdata,
   input wire logic                   avs_waitrequest,
   input wire logic                   count_tick,
   input wire mtsl_pkg::mtsl_src_type src_in,
   input wire logic                   measured_signal,
   input wire logic                   period_match,
   input wire logic                   irq
);
   logic [4:0]  sel_q;
   logic [2:0]  mask_q;
   logic [1:0]  exp_q;
   logic [1:0]  vld_q;
   logic [16:0] src_v;
   logic        want;
   logic        wr_done;
   assign wr_done = avs_write && !avs_waitrequest;
   assign src_v = src_in;
   assign want = (sel_q < 5'h11) ? src_v[5'h10 - sel_q] : 1'b0;
   always_ff @(posedge clk) begin
      if (rst)
         sel_q <= 5'h00;
      else if (wr_done && avs_address == 5'h00)
         sel_q <= avs_writedata[4:0];
   end
   always_ff @(posedge clk) begin
      if (rst)
         mask_q <= 3'h0;
      else if (wr_done && avs_address == 5'h10)
         mask_q <= avs_writedata[2:0];
   end
   // Two flops of latency, so the expectation is piped the same way.
   always_ff @(posedge clk) begin
      exp_q <= {exp_q[0], want};
      vld_q <= rst ? 2'h0 : ((vld_q == 2'h3) ? vld_q : vld_q + 2'h1);
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence taken_s;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence answer_s;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   bus_answer_a: assert property (taken_s |=> answer_s)
      else $error("bus answer not after one wait cycle");
   unmapped_zero_a: assert property (taken_s and avs_read && avs_address > 5'h10
      |=> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
   sel_upper_a: assert property (
      taken_s and avs_read && avs_address == 5'h00
      |=> avs_readdata[31:5] == 27'h0) else $error("selector upper bits set");
   source_route_a: assert property (
      vld_q == 2'h3 |-> measured_signal == exp_q[1])
      else $error("measured signal not the selected source");
   match_tick_a: assert property (
      period_match |-> $past(count_tick)) else $error("match without tick");
   read_hold_a: assert property (!$past(avs_read && avs_waitrequest)
      |-> $stable(avs_readdata)) else $error("read data moved without read");
   irq_release_a: assert property ($fell(irq) |-> $past(wr_done)
      || $past(wr_done, 2) || $past(wr_done, 3))
      else $error("interrupt dropped without a write");
   irq_masked_a: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0
      |-> !irq) else $error("interrupt raised while masked");
endmodule : mtsl_checker
bind mtsl_top mtsl_checker checker_inst (.clk(clk), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .count_tick(count_tick),
   .src_in(src_in), .measured_signal(measured_signal),
   .period_match(period_match), .irq(irq));
`default_nettype wire

//--- test/mtsl_src_model.sv
// Model of the peripheral outputs that feed the signal selector.
// Assumes one clock shared with the block and a synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module mtsl_src_model (
   input  wire logic             clk,
   input  wire logic             rst,
   output mtsl_pkg::mtsl_src_type src
);
   logic [16:0] pat_reg;
   // Every source changes often, so a wrong selector code shows at once.
   always_ff @(posedge clk) begin
      if (rst)
         pat_reg <= 17'h0005f;
      else
         pat_reg <= {pat_reg[15:0], pat_reg[16] ^ pat_reg[13]};
   end
   assign src = mtsl_pkg::mtsl_src_type'(pat_reg);
endmodule : mtsl_src_model
`default_nettype wire

//--- test/test_mtsl_top.sv
// Testbench of the measurement timer: registers, selector, latches, match.
// Assumes the source model drives every signal source each cycle.
`timescale 1ns/1ns
`default_nettype none
module test_mtsl_top;
   logic                   clk = 1'b0;
   logic                   rst = 1'b1;
   logic [4:0]             avs_address = 5'h00;
   logic                   avs_read = 1'b0;
   logic                   avs_write = 1'b0;
   logic [31:0]            avs_writedata = 32'h0;
   logic [31:0]            avs_readdata;
   logic                   avs_waitrequest;
   logic                   count_tick = 1'b0;
   mtsl_pkg::mtsl_src_type src_in;
   logic                   period_capture = 1'b0;
   logic                   width_capture = 1'b0;
   logic                   measured_signal;
   logic                   period_match;
   logic                   irq;
   int                     errors = 0;
   int                     compares = 0;
   int                     cycles = 0;
   int                     pulses = 0;
   logic [15:0]            lfsr = 16'h005f;
   logic [31:0]            q;
   logic [23:0]            v;
   always #25 clk = ~clk;
   mtsl_src_model src_model (.clk(clk), .rst(rst), .src(src_in));
   mtsl_top dut (.clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .count_tick(count_tick),
      .src_in(src_in), .period_capture(period_capture),
      .width_capture(width_capture), .measured_signal(measured_signal),
      .period_match(period_match), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr_step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_step
   // Counter value after n counting ticks: wrap or hold at the limit.
   function automatic logic [23:0] after_ticks(input logic [23:0] s,
      input logic [23:0] lim, input int n, input logic halt);
      logic [23:0] c;
      c = s;
      for (int k = 0; k < n; k++) begin
         if (c == lim) begin
            c = halt ? lim : 24'h000000;
         end else begin
            c = c + 24'h000001;
         end
      end
      return c;
   endfunction : after_ticks
   task automatic roll();
      lfsr = lfsr_step(lfsr);
      v = {lfsr[7:0], lfsr ^ 16'h5a5a};
   endtask : roll
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Request is held until waitrequest is seen low, then released.
   task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(q, exp);
   endtask : rd
   task automatic put24(input logic [4:0] a, input logic [23:0] d);
      for (int i = 0; i < 3; i++) bus(1'b1, a + 5'(i), {24'h0, d[8*i +: 8]});
   endtask : put24
   task automatic get24(input logic [4:0] a, input logic [23:0] exp);
      for (int i = 0; i < 3; i++) rd(a + 5'(i), {24'h0, exp[8*i +: 8]});
   endtask : get24
   task automatic ticks(input int n);
      count_tick <= 1'b1;
      repeat (n) @(posedge clk);
      count_tick <= 1'b0;
      @(posedge clk);
   endtask : ticks
   task automatic print_verdict();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(mtsl_pkg::A_SIG, 32'h0);
      get24(mtsl_pkg::A_TMR_L, 24'h0);
      get24(mtsl_pkg::A_LIM_L, 24'hffffff);
      bus(1'b1, 5'h1f, 32'hffffffff);
      rd(5'h1f, 32'h0);
      $display("test reset values done");
      for (int c = 0; c < 32; c++) begin
         bus(1'b1, mtsl_pkg::A_SIG, 32'(c) | 32'he0);
         repeat (4) @(posedge clk);
         rd(mtsl_pkg::A_SIG, 32'(c));
      end
      $display("test source select done");
      for (int i = 0; i < 4; i++) begin
         roll();
         put24(mtsl_pkg::A_TMR_L, v);
         get24(mtsl_pkg::A_TMR_L, v);
         bus(1'b1, mtsl_pkg::A_STAT, 32'h3);
         bus(1'b0, mtsl_pkg::A_STAT, 32'h0);
         check(q & 32'h3, 32'h0);
         put24(mtsl_pkg::A_CPR_L, ~v);
         put24(mtsl_pkg::A_CPW_L, ~v);
         get24(mtsl_pkg::A_CPR_L, v);
         get24(mtsl_pkg::A_CPW_L, v);
      end
      roll();
      put24(mtsl_pkg::A_TMR_L, v);
      period_capture <= 1'b1;
      width_capture <= 1'b1;
      @(posedge clk);
      period_capture <= 1'b0;
      width_capture <= 1'b0;
      @(posedge clk);
      get24(mtsl_pkg::A_CPR_L, v);
      get24(mtsl_pkg::A_CPW_L, v);
      $display("test latches done");
      // A limit of five: the sixth tick meets it and wraps to zero.
      put24(mtsl_pkg::A_TMR_L, 24'h0);
      put24(mtsl_pkg::A_LIM_L, 24'h5);
      bus(1'b1, mtsl_pkg::A_IRQ_ST, 32'h7);
      bus(1'b1, mtsl_pkg::A_IRQ_MSK, 32'h1);
      bus(1'b1, mtsl_pkg::A_CTRL, 32'h1);
      ticks(6);
      bus(1'b1, mtsl_pkg::A_CTRL, 32'h0);
      get24(mtsl_pkg::A_TMR_L, after_ticks(24'h0, 24'h5, 6, 1'b0));
      rd(mtsl_pkg::A_IRQ_ST, 32'h1);
      check({31'h0, irq}, 32'h1);
      check(32'(pulses), 32'h1);
      bus(1'b1, mtsl_pkg::A_IRQ_ST, 32'h1);
      rd(mtsl_pkg::A_IRQ_ST, 32'h0);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, mtsl_pkg::A_IRQ_MSK, 32'h0);
      bus(1'b1, mtsl_pkg::A_CTRL, 32'h3);
      ticks(8);
      bus(1'b1, mtsl_pkg::A_CTRL, 32'h2);
      get24(mtsl_pkg::A_TMR_L, after_ticks(24'h0, 24'h5, 8, 1'b1));
      rd(mtsl_pkg::A_IRQ_ST, 32'h1);
      check({31'h0, irq}, 32'h0);
      // Held at the limit, each of the last three ticks matches again.
      check(32'(pulses), 32'h4);
      bus(1'b1, mtsl_pkg::A_STAT, 32'h4);
      get24(mtsl_pkg::A_TMR_L, 24'h0);
      $display("test period match done");
      print_verdict();
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (period_match === 1'b1) begin
         pulses <= pulses + 1;
      end
      if (cycles == 5000) begin
         errors++;
         print_verdict();
      end
   end
endmodule : test_mtsl_top
`default_nettype wire
